// *** src/fsk_pkg.sv ***
package fsk_pkg;
    // ****************************************************
    // clock and timing
    // ****************************************************
    localparam longint CLK_HZ = 125_000_000;
    localparam longint SAMPLE_RATE_HZ = 1_000_000;
    localparam int SAMPLE_CYCLES = int'(CLK_HZ / SAMPLE_RATE_HZ);
    localparam real BIT_PERIOD_MS = 5.12;
    localparam logic [31:0] BIT_PERIOD_DEFAULT = 32'(int'(BIT_PERIOD_MS * 1.0e-3 * real'(CLK_HZ)));
    // ****************************************************
    // tones, in hz
    // ****************************************************
    localparam longint MARK_HZ = 131_250;
    localparam longint SPACE_HZ = 143_750;
    localparam logic [31:0] PWM_INC_MARK = 32'((MARK_HZ << 32) / CLK_HZ);
    localparam logic [31:0] PWM_INC_SPACE = 32'((SPACE_HZ << 32) / CLK_HZ);
    localparam logic [31:0] PWM_DUTY_HI = 32'ha8f5_c28f;
    localparam logic [31:0] PWM_DUTY_LO = 32'h5555_5555;
    // ****************************************************
    // sine table phase, 13.12 fixed point
    // ****************************************************
    localparam int TABLE_BITS = 12;
    localparam longint TABLE_LEN = 4096;
    localparam int FRAC_BITS = 12;
    localparam int POS_W = 25;
    localparam logic [24:0] POS_TOP = 25'h100_0000;
    localparam logic [24:0] POS_WRAP = 25'h0ff_f000;
    localparam logic [24:0] STEP_MARK =
        25'(((MARK_HZ * TABLE_LEN) << FRAC_BITS) / SAMPLE_RATE_HZ);
    localparam logic [24:0] STEP_SPACE =
        25'(((SPACE_HZ * TABLE_LEN) << FRAC_BITS) / SAMPLE_RATE_HZ);
    localparam int DAC_W = 10;
    localparam logic [9:0] DAC_MID = 10'h200;
    // ****************************************************
    // packet
    // ****************************************************
    localparam logic [7:0] PKT_BITS = 8'h21;
    localparam logic [7:0] CYCLE_LAST = 8'hd0;
    localparam logic [3:0] WORD_LAST = 4'ha;
    // first element in the msb, one = mark
    localparam logic [10:0] WORD_ONE = 11'h0ed;
    localparam logic [10:0] WORD_ZERO = 11'h712;
    // ****************************************************
    // spi
    // ****************************************************
    localparam int SPI_W = 16;
    localparam logic [3:0] SPI_LAST_BIT = 4'hf;
    typedef enum logic [0:0] {
        FSK_SPI_IDLE = 1'b0,
        FSK_SPI_SHIFT = 1'b1
    } fsk_spi_state_t;
endpackage : fsk_pkg

// *** src/fsk_stream_if.sv ***
interface fsk_stream_if;
    logic [15:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : fsk_stream_if

// *** src/fsk_buf.sv ***
module fsk_buf
    import fsk_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    fsk_stream_if.snk in_s,
    fsk_stream_if.src out_s
);
    // ****************************************************
    // two slots used in turn
    // ****************************************************
    logic [15:0] slot [2];
    logic wr_sel;
    logic rd_sel;
    logic [1:0] fill;
    logic push;
    logic pop;

    assign in_s.ready = (fill != 2'h2);
    assign out_s.valid = (fill != 2'h0);
    assign out_s.data = slot[rd_sel];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    // fill one slot while the other drains
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            slot[wr_sel] <= in_s.data;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            wr_sel <= 1'b0;
            rd_sel <= 1'b0;
            fill <= 2'h0;
        end else begin
            if (push) begin
                wr_sel <= ~wr_sel;
            end
            if (pop) begin
                rd_sel <= ~rd_sel;
            end
            fill <= 2'(fill + {1'b0, push} - {1'b0, pop});
        end
    end

    property p_buf_swap;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        pop |=> rd_sel != $past(rd_sel);
    endproperty
    a_buf_swap: assert property (p_buf_swap) else $error("buffer source did not swap");

    property p_buf_bound;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (fill == 2'h2 && !pop) |=> fill == 2'h2 && $stable(wr_sel);
    endproperty
    a_buf_bound: assert property (p_buf_bound) else $error("full buffer took a word");
endmodule : fsk_buf

// *** src/fsk_keepalive_transmitter.sv ***
// Behaviour
// - bit timer raises per-bit event; separate tone source sets frequency
// - cycle count advances once per bit; packet is three 11-bit words
// - each bit event picks mark or space tone from the next bit
// - pwm outputs stop after 33 bit periods and stay quiet
// - converter samples stop after 33 bit periods and stay quiet
// - after count 208 the count restarts and the packet repeats
// - WORD_ONE (11'h0ed) packet when selection is set, WORD_ZERO (11'h712) packet when selection is cleared
// - periodic sample event sends one sine sample over spi
// - 4096-entry table at 1 mhz, fractional position plus fractional step
// - read table at integer position; subtract 4095 when above 4095
// - per-bit event changes the phase step to mark or space
// - two buffers, each word moved to spi, swap on drain
// - mark tone 131.25 khz, space tone 143.75 khz
module fsk_keepalive_transmitter
    import fsk_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic enable_i,
    input wire logic dac_mode_i,
    input wire logic packet_selection_i,
    input wire logic [31:0] bit_period_i,
    output logic pwm_hi_o,
    output logic pwm_lo_o,
    output logic dac_mode_sel_o,
    output logic spi_sclk_o,
    output logic spi_mosi_o,
    output logic spi_cs_b_o,
    output logic tx_active_o,
    output logic [7:0] cycle_count_o
);
    // ****************************************************
    // bit rate timer
    // ****************************************************
    logic [31:0] bit_timer;
    logic bit_tick;
    logic [7:0] cycle_count;
    logic [3:0] word_idx;
    logic [10:0] word;
    logic tone_mark;
    logic tx_active;

    assign bit_tick = enable_i && (bit_timer >= 32'(bit_period_i - 32'h1));

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || !enable_i || bit_tick) begin
            bit_timer <= 32'h0;
        end else begin
            bit_timer <= 32'(bit_timer + 32'h1);
        end
    end

    // one count per bit, word index alongside
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || !enable_i) begin
            cycle_count <= 8'h0;
            word_idx <= 4'h0;
        end else if (bit_tick) begin
            if (cycle_count == CYCLE_LAST) begin
                cycle_count <= 8'h0;
                word_idx <= 4'h0;
            end else begin
                cycle_count <= 8'(cycle_count + 8'h1);
                word_idx <= (word_idx == WORD_LAST) ? 4'h0 : 4'(word_idx + 4'h1);
            end
        end
    end

    assign word = packet_selection_i ? WORD_ONE : WORD_ZERO;
    // first element first, one is mark
    assign tone_mark = word[4'(WORD_LAST - word_idx)];
    assign tx_active = enable_i && (cycle_count < PKT_BITS);

    // ****************************************************
    // pwm tone pair
    // ****************************************************
    logic [31:0] pwm_phase;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || !tx_active) begin
            pwm_phase <= 32'h0;
        end else begin
            pwm_phase <= 32'(pwm_phase + (tone_mark ? PWM_INC_MARK : PWM_INC_SPACE));
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pwm_hi_o <= 1'b0;
            pwm_lo_o <= 1'b0;
        end else begin
            pwm_hi_o <= tx_active && !dac_mode_i && (pwm_phase < PWM_DUTY_HI);
            pwm_lo_o <= tx_active && !dac_mode_i && (pwm_phase < PWM_DUTY_LO);
        end
    end

    // ****************************************************
    // converter sample stream
    // ****************************************************
    logic [6:0] samp_timer;
    logic samp_tick;
    logic [24:0] table_phase_position;
    logic [24:0] pos_sum;
    logic [24:0] table_phase_increment;
    logic [15:0] samp_word;
    logic samp_valid;
    logic dac_on;
    fsk_stream_if samp_s ();
    fsk_stream_if spi_s ();

    assign dac_on = tx_active && dac_mode_i;
    assign samp_tick = (samp_timer == 7'(SAMPLE_CYCLES - 1));
    assign table_phase_increment = tone_mark ? STEP_MARK : STEP_SPACE;
    assign pos_sum = 25'(table_phase_position + table_phase_increment);

    // sine from a parabola per half cycle, indexed by the 12-bit table position
    function automatic logic [15:0] fsk_table(input logic [11:0] idx);
        logic [21:0] prod;
        logic [9:0] mag;
        prod = 22'({11'h0, idx[10:0]} * (12'h800 - {1'b0, idx[10:0]}));
        mag = (prod[21:11] > 11'h1ff) ? 10'h1ff : prod[20:11];
        fsk_table = {6'h0, idx[11] ? 10'(DAC_MID - mag) : 10'(DAC_MID + mag)};
    endfunction : fsk_table

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || samp_tick) begin
            samp_timer <= 7'h0;
        end else begin
            samp_timer <= 7'(samp_timer + 7'h1);
        end
    end

    // a stalled sample holds its phase, so back-pressure loses no word
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            table_phase_position <= 25'h0;
            samp_word <= 16'h0;
            samp_valid <= 1'b0;
        end else begin
            if (samp_valid && samp_s.ready) begin
                samp_valid <= 1'b0;
            end
            // no new samples outside the packet
            if (samp_tick && dac_on && !(samp_valid && !samp_s.ready)) begin
                samp_word <= fsk_table(table_phase_position[23:12]);
                samp_valid <= 1'b1;
                table_phase_position <= (pos_sum > POS_WRAP) ? 25'(pos_sum - POS_WRAP) : pos_sum;
            end
        end
    end

    assign samp_s.data = samp_word;
    assign samp_s.valid = samp_valid;

    fsk_buf u_buf (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .in_s(samp_s),
        .out_s(spi_s)
    );

    // ****************************************************
    // spi shifter, four clocks per bit
    // ****************************************************
    fsk_spi_state_t spi_state;
    logic [15:0] shreg;
    logic [3:0] bit_left;
    logic [1:0] ph;

    assign spi_s.ready = (spi_state == FSK_SPI_IDLE);

    // word moved into the spi shifter
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            spi_state <= FSK_SPI_IDLE;
            shreg <= 16'h0;
            bit_left <= 4'h0;
            ph <= 2'h0;
            spi_sclk_o <= 1'b0;
            spi_mosi_o <= 1'b0;
            spi_cs_b_o <= 1'b1;
        end else begin
            case (spi_state)
                FSK_SPI_IDLE: begin
                    if (spi_s.valid) begin
                        shreg <= spi_s.data;
                        spi_mosi_o <= spi_s.data[SPI_W - 1];
                        spi_cs_b_o <= 1'b0;
                        bit_left <= SPI_LAST_BIT;
                        ph <= 2'h0;
                        spi_state <= FSK_SPI_SHIFT;
                    end
                end
                FSK_SPI_SHIFT: begin
                    ph <= 2'(ph + 2'h1);
                    if (ph == 2'h1) begin
                        spi_sclk_o <= 1'b1;
                    end
                    if (ph == 2'h3) begin
                        spi_sclk_o <= 1'b0;
                        if (bit_left == 4'h0) begin
                            spi_cs_b_o <= 1'b1;
                            spi_state <= FSK_SPI_IDLE;
                        end else begin
                            bit_left <= 4'(bit_left - 4'h1);
                            spi_mosi_o <= shreg[SPI_W - 2];
                            shreg <= {shreg[14:0], 1'b0};
                        end
                    end
                end
                default: begin
                    spi_state <= FSK_SPI_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            dac_mode_sel_o <= 1'b0;
            tx_active_o <= 1'b0;
            cycle_count_o <= 8'h0;
        end else begin
            dac_mode_sel_o <= dac_mode_i;
            tx_active_o <= tx_active;
            cycle_count_o <= cycle_count;
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    sequence s_last_bit;
        bit_tick && cycle_count == CYCLE_LAST;
    endsequence
    sequence s_restart;
        cycle_count == 8'h0 && word_idx == 4'h0;
    endsequence

    property p_restart;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        s_last_bit |=> s_restart;
    endproperty
    a_restart: assert property (p_restart) else $error("count did not restart");

    property p_count_step;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (bit_tick && cycle_count != CYCLE_LAST) |=> cycle_count == 8'($past(cycle_count) + 8'h1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count missed a bit");

    property p_tick_clear;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        bit_tick |=> bit_timer == 32'h0 && cycle_count != $past(cycle_count);
    endproperty
    a_tick_clear: assert property (p_tick_clear) else $error("bit event lost");

    property p_pwm_quiet;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (cycle_count >= PKT_BITS) |=> !pwm_hi_o && !pwm_lo_o;
    endproperty
    a_pwm_quiet: assert property (p_pwm_quiet) else $error("pwm during quiet");

    property p_tone_step;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (tx_active && $past(tx_active) && $past(rst_b_i)) |-> pwm_phase ==
            32'($past(pwm_phase) + ($past(tone_mark) ? PWM_INC_MARK : PWM_INC_SPACE));
    endproperty
    a_tone_step: assert property (p_tone_step) else $error("tone does not follow bit");

    property p_dac_quiet;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (!dac_on && !samp_valid) |=> !samp_valid;
    endproperty
    a_dac_quiet: assert property (p_dac_quiet) else $error("sample during quiet");

    property p_pos_range;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        $changed(table_phase_position) |-> table_phase_position < POS_TOP;
    endproperty
    a_pos_range: assert property (p_pos_range) else $error("position not wrapped");

    property p_samp_rate;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        samp_tick |=> !samp_tick [*8];
    endproperty
    a_samp_rate: assert property (p_samp_rate) else $error("sample event too often");

    property p_pos_step;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (samp_tick && dac_on && !samp_valid && pos_sum <= POS_WRAP) |=>
            table_phase_position == $past(pos_sum);
    endproperty
    a_pos_step: assert property (p_pos_step) else $error("wrong phase step");
endmodule : fsk_keepalive_transmitter

// *** test/fsk_afe_model.sv ***
module fsk_afe_model (
    input wire logic spi_sclk_i,
    input wire logic spi_mosi_i,
    input wire logic spi_cs_b_i,
    input wire logic dac_mode_sel_i,
    output int frames,
    output int bad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] word = 16'h0000;
    int nbits = 0;
    initial begin
        frames = 0;
        bad = 0;
    end
    // ****************************************************
    // receive side of the sample link
    // ****************************************************
    always @(posedge spi_sclk_i) begin
        if (spi_cs_b_i === 1'b0) begin
            word = {word[14:0], spi_mosi_i};
            nbits++;
        end
    end
    always @(negedge spi_cs_b_i) begin
        nbits = 0;
    end
    // partial frames only come from a reset in mid-frame
    always @(posedge spi_cs_b_i) begin
        if (nbits > 0) begin
            frames++;
            if (nbits != 16 || word[15:10] !== 6'h00) bad++;
            if (dac_mode_sel_i !== 1'b1) bad++;
        end
    end
endmodule : fsk_afe_model

// *** test/fsk_keepalive_transmitter_bench.sv ***
module fsk_keepalive_transmitter_bench;
    import fsk_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic dac;
        logic sel;
        logic [3:0] mk;
    } fsk_row_t;
    localparam int FAST = 40;
    localparam int SLOW = 2500;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic enable_i = 1'b0;
    logic dac_mode_i = 1'b0;
    logic packet_selection_i = 1'b1;
    logic [31:0] bit_period_i = 32'h0000_0028;
    logic pwm_hi_o, pwm_lo_o, dac_mode_sel_o, spi_sclk_o, spi_mosi_o, spi_cs_b_o;
    logic tx_active_o;
    logic [7:0] cycle_count_o;
    int frames, bad, fails, checks, cyc, act, qt, qbad, gbad, fs, lcs, pe, hi, wraps;
    int ival [4];
    logic [7:0] mx, pcnt;
    logic phi, pcs;
    fsk_row_t rows [4] = '{'{1'b0, 1'b1, 4'h8}, '{1'b0, 1'b0, 4'h7},
        '{1'b1, 1'b1, 4'h0}, '{1'b1, 1'b0, 4'h0}};
    fsk_keepalive_transmitter fsk_keepalive_transmitter_i (.sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i), .enable_i(enable_i), .dac_mode_i(dac_mode_i),
        .packet_selection_i(packet_selection_i), .bit_period_i(bit_period_i),
        .pwm_hi_o(pwm_hi_o), .pwm_lo_o(pwm_lo_o), .dac_mode_sel_o(dac_mode_sel_o),
        .spi_sclk_o(spi_sclk_o), .spi_mosi_o(spi_mosi_o), .spi_cs_b_o(spi_cs_b_o),
        .tx_active_o(tx_active_o), .cycle_count_o(cycle_count_o));
    fsk_afe_model fsk_afe_model_i (.spi_sclk_i(spi_sclk_o), .spi_mosi_i(spi_mosi_o),
        .spi_cs_b_i(spi_cs_b_o), .dac_mode_sel_i(dac_mode_sel_o),
        .frames(frames), .bad(bad));
    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    // ****************************************************
    // helpers
    // ****************************************************
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    task automatic clr();
        act = 0;
        qt = 0;
        qbad = 0;
        gbad = 0;
        fs = 0;
        hi = 0;
        wraps = 0;
        mx = 8'h00;
        ival = '{0, 0, 0, 0};
    endtask : clr
    task automatic start(input logic dac, input logic sel, input int per);
        rst_b_i = 1'b0;
        enable_i = 1'b1;
        dac_mode_i = dac;
        packet_selection_i = sel;
        bit_period_i = 32'(per);
        repeat (3) @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        clr();
    endtask : start
    // monitor runs at the falling edge, where outputs are settled
    task automatic step(input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge sys_clk_i);
            cyc++;
            if (tx_active_o === 1'b1) begin
                act++;
                qt = 0;
            end else begin
                qt++;
            end
            if (cycle_count_o > mx) mx = cycle_count_o;
            if (pcnt === CYCLE_LAST && cycle_count_o === 8'h00) wraps++;
            if (pwm_hi_o === 1'b1 || pwm_lo_o === 1'b1) hi++;
            if (qt > 2 && (pwm_hi_o !== 1'b0 || pwm_lo_o !== 1'b0)) qbad++;
            if (qt > 200 && spi_cs_b_o !== 1'b1) qbad++;
            if (qt > 200) fs = 0;
            if (pwm_hi_o === 1'b1 && phi === 1'b0) begin
                if (pcnt === cycle_count_o && cycle_count_o < 8'h04) begin
                    ival[int'(cycle_count_o)] = cyc - pe;
                end
                pe = cyc;
            end
            if (spi_cs_b_o === 1'b0 && pcs === 1'b1) begin
                if (fs > 0 && cyc - lcs != SAMPLE_CYCLES) gbad++;
                fs++;
                lcs = cyc;
            end
            phi = pwm_hi_o;
            pcs = spi_cs_b_o;
            pcnt = cycle_count_o;
        end
    endtask : step
    initial begin
        #640_000;
        fails++;
        finish_test();
    end
    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        int f0;
        int b0;
        fails = 0;
        checks = 0;
        cyc = 0;
        pe = 0;
        lcs = 0;
        phi = 1'b0;
        pcs = 1'b1;
        pcnt = 8'h00;
        foreach (rows[r]) begin
            start(rows[r].dac, rows[r].sel, SLOW);
            // a reset in mid-frame leaves one cut frame behind
            f0 = frames;
            b0 = bad;
            step(4 * SLOW);
            if (rows[r].dac == 1'b0) begin
                for (int i = 0; i < 4; i++) begin
                    chk((ival[i] > 910) === rows[r].mk[i], "tone of bit");
                end
            end else begin
                chk(frames - f0 > 70, "too few samples");
                chk(gbad == 0, "sample spacing");
                chk(hi == 0, "pwm in converter mode");
                chk(bad == b0, "sample word shape");
            end
            $display("test row %0d done", r);
        end
        foreach (rows[r]) begin
            if (r < 2) begin
                start(r == 1, 1'b1, FAST);
                f0 = frames;
                b0 = bad;
                step(209 * FAST);
                chk(act == 33 * FAST, "packet length");
                chk(mx === CYCLE_LAST && wraps == 0, "count range");
                chk(qbad == 0, "quiet broken");
                if (r == 1) begin
                    chk(frames - f0 >= 10 && frames - f0 <= 11, "frames per packet");
                    chk(gbad == 0 && bad == b0, "frame timing");
                end
                step(2 * FAST);
                chk(wraps == 1 && act > 33 * FAST, "no restart");
                $display("test full cycle %0d done", r);
            end
        end
        start(1'b0, 1'b1, FAST);
        step(3 * FAST);
        rst_b_i = 1'b0;
        step(1);
        chk(pwm_hi_o === 1'b0 && spi_cs_b_o === 1'b1, "outputs during reset");
        chk(tx_active_o === 1'b0 && cycle_count_o === 8'h00, "count during reset");
        rst_b_i = 1'b1;
        step(2);
        chk(tx_active_o === 1'b1 && cycle_count_o === 8'h00, "restart after reset");
        enable_i = 1'b0;
        step(3 * FAST);
        chk(tx_active_o === 1'b0 && cycle_count_o === 8'h00, "disabled run");
        $display("test reset and enable done");
        finish_test();
    end
endmodule : fsk_keepalive_transmitter_bench
